// [logic/umic_defs.vh]
/*
 * Register offsets, field positions, reset values and codes of the modem,
 * interrupt and enhanced-feature control block.
 * Assumes a three-bit register address on the parallel host port.
 */
`ifndef UMIC_DEFS_VH
`define UMIC_DEFS_VH

// =====================================================================
// Register offsets
// =====================================================================
`define UMIC_A_IER 3'h1
`define UMIC_A_IIR_FCR 3'h2
`define UMIC_A_MCR 3'h4
`define UMIC_A_MSR 3'h6
`define UMIC_A_TCR 3'h6
`define UMIC_A_TLR 3'h7
`define UMIC_A_RDY 3'h7

// =====================================================================
// Modem control fields
// =====================================================================
`define UMIC_MCR_DTR 0
`define UMIC_MCR_RTS 1
`define UMIC_MCR_RDY 2
`define UMIC_MCR_OUT 3
`define UMIC_MCR_LOOP 4
`define UMIC_MCR_XANY 5
`define UMIC_MCR_XACC 6
`define UMIC_MCR_DIV4 7

// =====================================================================
// Feature and interrupt enable fields
// =====================================================================
`define UMIC_EFR_WEN 4
`define UMIC_EFR_SPEC 5
`define UMIC_EFR_ARTS 6
`define UMIC_EFR_ACTS 7
`define UMIC_IER_RHR 0
`define UMIC_IER_THR 1
`define UMIC_IER_LSR 2
`define UMIC_IER_MSR 3
`define UMIC_IER_SLEEP 4
`define UMIC_IER_XOFF 5
`define UMIC_IER_RTSI 6
`define UMIC_IER_CTSI 7

// =====================================================================
// Masks of bits guarded by the feature write enable
// =====================================================================
`define UMIC_IER_PROT 8'hF0
`define UMIC_MCR_PROT 8'hE0
`define UMIC_FCR_PROT 8'h30

// =====================================================================
// Reset values
// =====================================================================
`define UMIC_RST_8 8'h00
`define UMIC_RST_MSR 4'h0

// =====================================================================
// Interrupt identification codes, bits 5:0
// =====================================================================
`define UMIC_ID_LSR 6'h06
`define UMIC_ID_TMO 6'h0C
`define UMIC_ID_RHR 6'h04
`define UMIC_ID_THR 6'h02
`define UMIC_ID_MDM 6'h00
`define UMIC_ID_XOF 6'h10
`define UMIC_ID_RC 6'h20

// =====================================================================
// Timing
// =====================================================================
`define UMIC_DIV4_COUNT 2'h3
`define UMIC_LEVEL_STEP 2

`endif

// [logic/umic_modem_irq.v]
/*
 * Per-channel modem control, modem status, interrupt enable, interrupt
 * identification and enhanced feature logic of a UART channel.
 * Assumes a synchronous host port (one-cycle read and write strobes on
 * ref_clk_in), a line-control decoder outside that raises efr_sel_in
 * while the feature register page is selected, and the FIFO data path
 * outside, which reports levels, characters and service events.
 */
`timescale 1ns/100ps
`include "umic_defs.vh"

module umic_modem_irq
#(
	parameter LEVEL_W = 7
)
(
	// Clock and reset
	input wire ref_clk_in,
	input wire rst_b_in,
	// Host register port
	input wire [2:0] host_addr_in,
	input wire [7:0] host_wdata_in,
	input wire host_wr_in,
	input wire host_rd_in,
	input wire efr_sel_in,
	output reg [7:0] host_rdata_out,
	// Modem lines, active low
	input wire cts_b_in,
	input wire dsr_b_in,
	input wire ri_b_in,
	input wire cd_b_in,
	output reg dtr_b_out,
	output reg rts_b_out,
	output reg general_output_pin_b_out,
	// Interrupt pin with enable
	output reg irq_out,
	output reg irq_oe_out,
	// Serial path
	input wire rx_pin_in,
	input wire tx_serial_in,
	output reg tx_pin_out,
	output reg rx_serial_out,
	// Data path status and events
	input wire rx_line_err_in,
	input wire rx_timeout_in,
	input wire rx_data_ready_in,
	input wire thr_empty_in,
	input wire xoff_rcvd_in,
	input wire rx_char_valid_in,
	input wire [7:0] rx_char_in,
	input wire [7:0] xoff2_char_in,
	input wire [LEVEL_W-1:0] rx_level_in,
	input wire [7:0] fifo_rdy_in,
	// Control toward data path
	output reg baud_tick_out,
	output reg tx_halt_out,
	output reg sleep_en_out,
	output reg xon_any_out,
	output reg [3:0] sw_flow_mode_out,
	output reg fifo_en_out,
	output reg [1:0] tx_trig_sel_out,
	output reg [7:0] trigger_level_out
);

	// =================================================================
	// Registers
	// =================================================================
	reg [7:0] modem_control_reg_r;
	reg [7:0] irq_enable_reg_r;
	reg [7:0] feature_enable_reg_r;
	reg [7:0] flow_threshold_reg_r;
	reg [3:0] msr_delta_r;
	reg [3:0] msr_prev_r;
	reg fcr_en_r;
	reg [1:0] fcr_trig_r;
	reg [7:0] tlr_r;
	reg [3:0] s1_r;
	reg [3:0] s2_r;
	reg [3:0] s3_r;
	reg [3:0] line_r;
	reg rx1_r;
	reg rx2_r;
	reg rx3_r;
	reg rx_line_r;
	reg thr_irq_r;
	reg thr_prev_r;
	reg xoff_irq_r;
	reg spec_irq_r;
	reg rc_irq_r;
	reg rts_halt_r;
	reg rts_halt_nxt;
	reg [1:0] div_r;

	// =================================================================
	// Decode
	// =================================================================
	wire loop = modem_control_reg_r[`UMIC_MCR_LOOP];
	wire wen = feature_enable_reg_r[`UMIC_EFR_WEN];
	wire xacc = modem_control_reg_r[`UMIC_MCR_XACC] & wen;
	wire wr_ier = host_wr_in & ~efr_sel_in & (host_addr_in == `UMIC_A_IER);
	wire wr_fcr = host_wr_in & ~efr_sel_in &
		(host_addr_in == `UMIC_A_IIR_FCR);
	wire wr_efr = host_wr_in & efr_sel_in &
		(host_addr_in == `UMIC_A_IIR_FCR);
	wire wr_mcr = host_wr_in & (host_addr_in == `UMIC_A_MCR);
	wire wr_tcr = host_wr_in & xacc & (host_addr_in == `UMIC_A_TCR);
	wire wr_tlr = host_wr_in & xacc & (host_addr_in == `UMIC_A_TLR);
	wire rd_msr = host_rd_in & ~xacc & (host_addr_in == `UMIC_A_MSR);
	wire rd_iir = host_rd_in & ~efr_sel_in &
		(host_addr_in == `UMIC_A_IIR_FCR);

	// =================================================================
	// Modem status sources: cts, dsr, ri, cd, all active high
	// =================================================================
	wire [3:0] msr_src = loop ?
		{modem_control_reg_r[`UMIC_MCR_OUT],
		modem_control_reg_r[`UMIC_MCR_RDY],
		modem_control_reg_r[`UMIC_MCR_DTR],
		modem_control_reg_r[`UMIC_MCR_RTS]} : ~line_r;
	wire [3:0] msr_chg = msr_src ^ msr_prev_r;
	// Ring pin low-to-high, or control bit 2 rising in loopback
	wire ri_set = loop ? (msr_src[2] & ~msr_prev_r[2]) :
		(~msr_src[2] & msr_prev_r[2]);
	wire [3:0] msr_set = {msr_chg[3], ri_set, msr_chg[1],
		msr_chg[0]};
	wire [7:0] msr_value = {msr_src, msr_delta_r};

	// =================================================================
	// Interrupt priority encoder
	// =================================================================
	wire en_lsr = irq_enable_reg_r[`UMIC_IER_LSR] & rx_line_err_in;
	wire en_tmo = irq_enable_reg_r[`UMIC_IER_RHR] & rx_timeout_in;
	wire en_rhr = irq_enable_reg_r[`UMIC_IER_RHR] & rx_data_ready_in;
	wire en_thr = irq_enable_reg_r[`UMIC_IER_THR] & thr_irq_r;
	wire en_mdm = irq_enable_reg_r[`UMIC_IER_MSR] & (|msr_delta_r);
	wire en_xof = irq_enable_reg_r[`UMIC_IER_XOFF] &
		(xoff_irq_r | spec_irq_r);
	wire en_rc = rc_irq_r;
	wire pending = en_lsr | en_tmo | en_rhr | en_thr | en_mdm |
		en_xof | en_rc;
	reg [5:0] iir_code;

	always @*
	begin
		// Highest priority wins; lower ones show once it is serviced
		if (en_lsr)
			iir_code = `UMIC_ID_LSR;
		else if (en_tmo)
			iir_code = `UMIC_ID_TMO;
		else if (en_rhr)
			iir_code = `UMIC_ID_RHR;
		else if (en_thr)
			iir_code = `UMIC_ID_THR;
		else if (en_mdm)
			iir_code = `UMIC_ID_MDM;
		else if (en_xof)
			iir_code = `UMIC_ID_XOF;
		else if (en_rc)
			iir_code = `UMIC_ID_RC;
		else
			iir_code = `UMIC_ID_MDM;
	end

	wire [7:0] iir_value = {fcr_en_r, fcr_en_r, iir_code[5:1],
		~pending};
	wire rep_thr = rd_iir & (iir_code == `UMIC_ID_THR) & pending;
	wire rep_xof = rd_iir & (iir_code == `UMIC_ID_XOF) & pending;
	wire rep_rc = rd_iir & (iir_code == `UMIC_ID_RC) & pending;

	// =================================================================
	// Flow control levels, in units of four characters
	// =================================================================
	wire [LEVEL_W-1:0] halt_lvl =
		{{(LEVEL_W-6){1'b0}}, flow_threshold_reg_r[3:0], 2'b00};
	wire [LEVEL_W-1:0] resume_lvl =
		{{(LEVEL_W-6){1'b0}}, flow_threshold_reg_r[7:4], 2'b00};
	wire spec_hit = feature_enable_reg_r[`UMIC_EFR_SPEC] &
		rx_char_valid_in & (rx_char_in == xoff2_char_in);

	// =================================================================
	// Read data mux
	// =================================================================
	reg [7:0] rd_mux;

	always @*
	begin
		rd_mux = 8'h00;
		case (host_addr_in)
		`UMIC_A_IER:
			rd_mux = irq_enable_reg_r;
		`UMIC_A_IIR_FCR:
			rd_mux = efr_sel_in ? feature_enable_reg_r : iir_value;
		`UMIC_A_MCR:
			rd_mux = modem_control_reg_r;
		`UMIC_A_MSR:
			rd_mux = xacc ? flow_threshold_reg_r : msr_value;
		`UMIC_A_TLR:
			if (xacc)
				rd_mux = tlr_r;
			else if (modem_control_reg_r[`UMIC_MCR_RDY] & ~loop)
				rd_mux = fifo_rdy_in;
			else
				rd_mux = 8'h00;
		default:
			rd_mux = 8'h00;
		endcase
	end

	// =================================================================
	// Pin synchronisers, three stages, change taken when 2 and 3 agree
	// =================================================================
	always @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			s1_r <= 4'hF;
			s2_r <= 4'hF;
			s3_r <= 4'hF;
			line_r <= 4'hF;
			rx1_r <= 1'b1;
			rx2_r <= 1'b1;
			rx3_r <= 1'b1;
			rx_line_r <= 1'b1;
		end
		else
		begin
			s1_r <= {cd_b_in, ri_b_in, dsr_b_in, cts_b_in};
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				line_r <= s3_r;
			rx1_r <= rx_pin_in;
			rx2_r <= rx1_r;
			rx3_r <= rx2_r;
			if (rx2_r == rx3_r)
				rx_line_r <= rx3_r;
		end
	end

	// =================================================================
	// Register writes
	// =================================================================
	always @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			modem_control_reg_r <= `UMIC_RST_8;
			irq_enable_reg_r <= `UMIC_RST_8;
			feature_enable_reg_r <= `UMIC_RST_8;
			flow_threshold_reg_r <= `UMIC_RST_8;
			tlr_r <= `UMIC_RST_8;
			fcr_en_r <= 1'b0;
			fcr_trig_r <= 2'b00;
		end
		else
		begin
			if (wr_mcr)
				modem_control_reg_r <= wen ? host_wdata_in :
					((host_wdata_in & ~`UMIC_MCR_PROT) |
					(modem_control_reg_r & `UMIC_MCR_PROT));
			if (wr_ier)
				irq_enable_reg_r <= wen ? host_wdata_in :
					((host_wdata_in & ~`UMIC_IER_PROT) |
					(irq_enable_reg_r & `UMIC_IER_PROT));
			if (wr_fcr)
			begin
				fcr_en_r <= host_wdata_in[0];
				if (wen)
					fcr_trig_r <= host_wdata_in[5:4];
			end
			if (wr_efr)
				feature_enable_reg_r <= host_wdata_in;
			if (wr_tcr)
				flow_threshold_reg_r <= host_wdata_in;
			if (wr_tlr)
				tlr_r <= host_wdata_in;
		end
	end

	// =================================================================
	// Modem status deltas and interrupt flags; a set beats a clear
	// =================================================================
	always @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			msr_delta_r <= `UMIC_RST_MSR;
			msr_prev_r <= `UMIC_RST_MSR;
			thr_irq_r <= 1'b0;
			thr_prev_r <= 1'b0;
			xoff_irq_r <= 1'b0;
			spec_irq_r <= 1'b0;
			rc_irq_r <= 1'b0;
		end
		else
		begin
			msr_prev_r <= msr_src;
			msr_delta_r <= (rd_msr ? 4'h0 : msr_delta_r) |
				msr_set;
			thr_prev_r <= thr_empty_in;
			if (thr_empty_in & ~thr_prev_r)
				thr_irq_r <= 1'b1;
			else if (rep_thr | ~thr_empty_in)
				thr_irq_r <= 1'b0;
			if (xoff_rcvd_in)
				xoff_irq_r <= 1'b1;
			else if (rep_xof)
				xoff_irq_r <= 1'b0;
			if (spec_hit)
				spec_irq_r <= 1'b1;
			else if (rep_xof)
				spec_irq_r <= 1'b0;
			if ((irq_enable_reg_r[`UMIC_IER_CTSI] & msr_chg[0] &
				~msr_src[0]) |
				(irq_enable_reg_r[`UMIC_IER_RTSI] & rts_halt_nxt &
				~rts_halt_r))
				rc_irq_r <= 1'b1;
			else if (rep_rc)
				rc_irq_r <= 1'b0;
		end
	end

	// =================================================================
	// Auto RTS hysteresis and prescaler
	// =================================================================
	always @*
	begin
		rts_halt_nxt = rts_halt_r;
		if (!feature_enable_reg_r[`UMIC_EFR_ARTS])
			rts_halt_nxt = 1'b0;
		else if (rx_level_in >= halt_lvl)
			rts_halt_nxt = 1'b1;
		else if (rx_level_in <= resume_lvl)
			rts_halt_nxt = 1'b0;
	end

	always @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rts_halt_r <= 1'b0;
			div_r <= 2'b00;
		end
		else
		begin
			rts_halt_r <= rts_halt_nxt;
			if (!modem_control_reg_r[`UMIC_MCR_DIV4] |
				(div_r == `UMIC_DIV4_COUNT))
				div_r <= 2'b00;
			else
				div_r <= div_r + 2'b01;
		end
	end

	// =================================================================
	// Registered outputs
	// =================================================================
	always @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			host_rdata_out <= 8'h00;
			dtr_b_out <= 1'b1;
			rts_b_out <= 1'b1;
			general_output_pin_b_out <= 1'b1;
			irq_out <= 1'b0;
			irq_oe_out <= 1'b0;
			tx_pin_out <= 1'b1;
			rx_serial_out <= 1'b1;
			baud_tick_out <= 1'b0;
			tx_halt_out <= 1'b0;
			sleep_en_out <= 1'b0;
			xon_any_out <= 1'b0;
			sw_flow_mode_out <= 4'h0;
			fifo_en_out <= 1'b0;
			tx_trig_sel_out <= 2'b00;
			trigger_level_out <= 8'h00;
		end
		else
		begin
			if (host_rd_in)
				host_rdata_out <= rd_mux;
			// In loopback the DTR and RTS pins rest inactive
			dtr_b_out <= loop |
				~modem_control_reg_r[`UMIC_MCR_DTR];
			if (loop)
				rts_b_out <= 1'b1;
			else if (feature_enable_reg_r[`UMIC_EFR_ARTS])
				rts_b_out <= rts_halt_nxt;
			else
				rts_b_out <= ~modem_control_reg_r[`UMIC_MCR_RTS];
			general_output_pin_b_out <=
				~modem_control_reg_r[`UMIC_MCR_OUT];
			irq_oe_out <= modem_control_reg_r[`UMIC_MCR_OUT];
			irq_out <= pending &
				modem_control_reg_r[`UMIC_MCR_OUT];
			tx_pin_out <= loop | tx_serial_in;
			rx_serial_out <= loop ? tx_serial_in : rx_line_r;
			baud_tick_out <= (div_r == 2'b00);
			tx_halt_out <= feature_enable_reg_r[`UMIC_EFR_ACTS] &
				~msr_src[0];
			sleep_en_out <= irq_enable_reg_r[`UMIC_IER_SLEEP];
			xon_any_out <= modem_control_reg_r[`UMIC_MCR_XANY];
			sw_flow_mode_out <= feature_enable_reg_r[3:0];
			fifo_en_out <= fcr_en_r;
			tx_trig_sel_out <= fcr_trig_r;
			trigger_level_out <= tlr_r;
		end
	end

endmodule

// [verification/umic_modem_props.sv]
/* Checker of the modem and interrupt control block.
 * Sees only the block's ports; bound to every instance of it. */
`timescale 1ns/100ps
module umic_modem_props
(
	// Clock, reset and host port
	input wire ref_clk_in,
	input wire rst_b_in,
	input wire [2:0] host_addr_in,
	input wire [7:0] host_wdata_in,
	input wire host_wr_in,
	input wire host_rd_in,
	input wire efr_sel_in,
	input wire [7:0] host_rdata_out,
	// Pins and controls
	input wire cts_b_in,
	input wire dtr_b_out,
	input wire rts_b_out,
	input wire general_output_pin_b_out,
	input wire irq_out,
	input wire irq_oe_out,
	input wire tx_pin_out,
	input wire baud_tick_out,
	input wire tx_halt_out
);
	wire mcr_wr = host_wr_in && host_addr_in == 3'h4;
	wire iir_rd = host_rd_in && host_addr_in == 3'h2 && !efr_sel_in;
	wire nul_rd = host_rd_in && (host_addr_in == 3'h0 ||
		host_addr_in == 3'h3 || host_addr_in == 3'h5);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence mcr_plain;
		mcr_wr && !host_wdata_in[4] ##1 !mcr_wr;
	endsequence
	a_dtr_drive: assert property
		(mcr_plain |-> ##1 dtr_b_out == !$past(host_wdata_in[0], 2))
		else $error("DTR pin wrong after write");
	a_op_drive: assert property
		(mcr_plain |-> ##1 general_output_pin_b_out ==
		!$past(host_wdata_in[3], 2) && irq_oe_out == $past(host_wdata_in[3], 2))
		else $error("output pin or irq enable wrong");
	a_irq_tristate: assert property (!irq_oe_out |-> !irq_out)
		else $error("irq driven while disabled");
	a_loop_quiet: assert property
		(mcr_wr && host_wdata_in[4] ##1 !mcr_wr |-> ##1
		dtr_b_out && rts_b_out && tx_pin_out)
		else $error("pins active in loopback");
	a_prescale_gap: assert property
		($fell(baud_tick_out) |-> !baud_tick_out[*3])
		else $error("prescaler tick too early");
	a_cts_release: assert property (!cts_b_in[*8] |-> !tx_halt_out)
		else $error("halt while CTS active");
	a_iir_code: assert property
		(iir_rd |=> host_rdata_out[5:0] inside {6'h01, 6'h06, 6'h0C,
		6'h04, 6'h02, 6'h00, 6'h10, 6'h20})
		else $error("illegal ident code");
	a_iir_mirror: assert property
		(iir_rd |=> host_rdata_out[7] == host_rdata_out[6])
		else $error("ident high bits differ");
	a_null_read: assert property (nul_rd |=> host_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!host_rd_in |=> $stable(host_rdata_out))
		else $error("read data moved without read");
	c_loop: cover property (mcr_wr && host_wdata_in[4]);
	c_irq: cover property (irq_out);
	c_halt: cover property (tx_halt_out);
endmodule
bind umic_modem_irq umic_modem_props i_umic_modem_props
(
	.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
	.host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in),
	.host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
	.efr_sel_in(efr_sel_in), .host_rdata_out(host_rdata_out),
	.cts_b_in(cts_b_in), .dtr_b_out(dtr_b_out), .rts_b_out(rts_b_out),
	.general_output_pin_b_out(general_output_pin_b_out),
	.irq_out(irq_out), .irq_oe_out(irq_oe_out), .tx_pin_out(tx_pin_out),
	.baud_tick_out(baud_tick_out), .tx_halt_out(tx_halt_out)
);

// [verification/umic_modem_peer.sv]
/* Modem model on the handshake lines.
 * Drives the active-low status lines; can echo RTS to CTS slowly. */
`timescale 1ns/100ps
module umic_modem_peer
(
	// Clock and reset
	input wire ref_clk_in,
	input wire rst_b_in,
	// Commands from the bench
	input wire follow_in,
	input wire [3:0] slow_in,
	input wire [3:0] line_on_in,
	// Handshake lines
	input wire rts_b_in,
	output reg cts_b_out,
	output reg dsr_b_out,
	output reg ri_b_out,
	output reg cd_b_out
);
	reg [3:0] wait_r;

	always @(posedge ref_clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			{cts_b_out, dsr_b_out, ri_b_out, cd_b_out} <= 4'hF;
			wait_r <= 4'h0;
		end
		else if (!follow_in)
			{cd_b_out, ri_b_out, dsr_b_out, cts_b_out} <= ~line_on_in;
		else if (cts_b_out == rts_b_in)
			wait_r <= 4'h0;
		else if (wait_r >= slow_in)
			cts_b_out <= rts_b_in;
		else
			wait_r <= wait_r + 4'h1;
endmodule

// [verification/uart_modem_irq_control_test.sv]
/* Self-checking bench of the modem and interrupt control block.
 * Host port and data path events come from here, handshake lines
 * from the modem model. */
`timescale 1ns/100ps
module uart_modem_irq_control_test;
	reg ref_clk_in, rst_b_in, host_wr_in, host_rd_in, efr_sel_in;
	reg [2:0] host_addr_in;
	reg [7:0] host_wdata_in, rx_char_in, xoff2_char_in, fifo_rdy_in;
	reg rx_pin_in, tx_serial_in, rx_line_err_in, rx_timeout_in;
	reg rx_data_ready_in, thr_empty_in, xoff_rcvd_in, rx_char_valid_in;
	reg [6:0] rx_level_in;
	reg follow, rd_d;
	reg [3:0] slow, line_on, e;
	reg [7:0] r, n, exp8;
	reg [7:0] exp_q[$];
	wire cts_b_in, dsr_b_in, ri_b_in, cd_b_in, dtr_b_out, rts_b_out;
	wire general_output_pin_b_out, irq_out, irq_oe_out, tx_pin_out;
	wire rx_serial_out, baud_tick_out, tx_halt_out, sleep_en_out;
	wire xon_any_out, fifo_en_out;
	wire [7:0] host_rdata_out, trigger_level_out;
	wire [3:0] sw_flow_mode_out;
	wire [1:0] tx_trig_sel_out;
	integer err_total, tests_run, cycles, i;

	umic_modem_irq #(.LEVEL_W(7)) i_umic_modem_irq
	(
		.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in),
		.host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
		.efr_sel_in(efr_sel_in), .host_rdata_out(host_rdata_out),
		.cts_b_in(cts_b_in), .dsr_b_in(dsr_b_in), .ri_b_in(ri_b_in),
		.cd_b_in(cd_b_in), .dtr_b_out(dtr_b_out), .rts_b_out(rts_b_out),
		.general_output_pin_b_out(general_output_pin_b_out),
		.irq_out(irq_out), .irq_oe_out(irq_oe_out), .rx_pin_in(rx_pin_in),
		.tx_serial_in(tx_serial_in), .tx_pin_out(tx_pin_out),
		.rx_serial_out(rx_serial_out), .rx_line_err_in(rx_line_err_in),
		.rx_timeout_in(rx_timeout_in), .rx_data_ready_in(rx_data_ready_in),
		.thr_empty_in(thr_empty_in), .xoff_rcvd_in(xoff_rcvd_in),
		.rx_char_valid_in(rx_char_valid_in), .rx_char_in(rx_char_in),
		.xoff2_char_in(xoff2_char_in), .rx_level_in(rx_level_in),
		.fifo_rdy_in(fifo_rdy_in), .baud_tick_out(baud_tick_out),
		.tx_halt_out(tx_halt_out), .sleep_en_out(sleep_en_out),
		.xon_any_out(xon_any_out), .sw_flow_mode_out(sw_flow_mode_out),
		.fifo_en_out(fifo_en_out), .tx_trig_sel_out(tx_trig_sel_out),
		.trigger_level_out(trigger_level_out)
	);
	umic_modem_peer i_umic_modem_peer
	(
		.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .follow_in(follow),
		.slow_in(slow), .line_on_in(line_on), .rts_b_in(rts_b_out),
		.cts_b_out(cts_b_in), .dsr_b_out(dsr_b_in), .ri_b_out(ri_b_in),
		.cd_b_out(cd_b_in)
	);

	// =====================================================
	// Host tasks and result monitor
	task check(input [7:0] seen, input [7:0] exp);
	begin
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task summarize;
	begin
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	task pause(input integer k);
		repeat (k) @(negedge ref_clk_in);
	endtask
	task wr(input [2:0] a, input [7:0] d, input sel);
	begin
		@(posedge ref_clk_in);
		host_addr_in <= a;
		host_wdata_in <= d;
		efr_sel_in <= sel;
		host_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		host_wr_in <= 1'b0;
	end
	endtask
	task rd(input [2:0] a, input [7:0] x, input sel);
	begin
		@(posedge ref_clk_in);
		host_addr_in <= a;
		efr_sel_in <= sel;
		host_rd_in <= 1'b1;
		exp_q.push_back(x);
		@(posedge ref_clk_in);
		host_rd_in <= 1'b0;
		pause(1);
	end
	endtask
	task do_reset;
	begin
		@(posedge ref_clk_in);
		rst_b_in <= 1'b0;
		repeat (10) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		pause(4);
	end
	endtask
	always @(posedge ref_clk_in)
		rd_d <= host_rd_in;
	always @(negedge ref_clk_in)
		if (rd_d)
			check(host_rdata_out, exp_q.pop_front());
	always @(posedge ref_clk_in)
	begin
		cycles = cycles + 1;
		if (cycles == 5000)
		begin
			err_total = err_total + 1;
			summarize;
		end
	end
	initial
	begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end

	// =====================================================
	// Tests
	initial
	begin
		{err_total, tests_run, cycles, rst_b_in, rd_d, follow} = 0;
		{host_wr_in, host_rd_in, efr_sel_in, tx_serial_in, rx_line_err_in,
			rx_timeout_in, rx_data_ready_in, thr_empty_in, xoff_rcvd_in,
			rx_char_valid_in, host_addr_in, rx_level_in} = 0;
		{host_wdata_in, rx_char_in, xoff2_char_in, slow, line_on} = 0;
		rx_pin_in = 1'b1;
		r = $urandom(32'h6bb2);
		r = $urandom;
		fifo_rdy_in = r;
		do_reset;
		rd(3'h1, 8'h00, 1'b0);
		rd(3'h2, 8'h01, 1'b0);
		rd(3'h2, 8'h00, 1'b1);
		for (i = 0; i < 6; i = i + 2)
			rd(i[2:0] + (i > 0), 8'h00, 1'b0);
		check({baud_tick_out, dtr_b_out, rts_b_out, general_output_pin_b_out,
			irq_oe_out}, 8'h1E);
		$display("test reset done");
		wr(3'h1, 8'hFF, 1'b0);
		rd(3'h1, 8'h0F, 1'b0);
		wr(3'h4, 8'hEF, 1'b0);
		rd(3'h4, 8'h0F, 1'b0);
		check({dtr_b_out, rts_b_out, general_output_pin_b_out, irq_oe_out},
			8'h01);
		rd(3'h7, r, 1'b0);
		wr(3'h4, 8'h0B, 1'b0);
		rd(3'h7, 8'h00, 1'b0);
		wr(3'h2, {4'h1, r[3:0]}, 1'b1);
		wr(3'h1, 8'hF0, 1'b0);
		wr(3'h2, 8'h31, 1'b0);
		wr(3'h4, 8'hE0, 1'b0);
		wr(3'h7, r, 1'b0);
		pause(2);
		check({sw_flow_mode_out, sleep_en_out, xon_any_out, tx_trig_sel_out},
			{r[3:0], 4'hF});
		check(trigger_level_out, r);
		check({7'h0, fifo_en_out}, 8'h01);
		rd(3'h2, 8'hC1, 1'b0);
		rd(3'h1, 8'hF0, 1'b0);
		n = 0;
		repeat (16)
		begin
			@(negedge ref_clk_in);
			n = n + baud_tick_out;
		end
		check(n, 8'h04);
		do_reset;
		$display("test protect done");
		e = {r[3], r[2], r[0], r[1]};
		@(posedge ref_clk_in);
		tx_serial_in <= r[5];
		wr(3'h4, {4'h1, r[3:0]}, 1'b0);
		pause(4);
		check({tx_pin_out, rx_serial_out, dtr_b_out, rts_b_out},
			{5'h01, r[5], 2'h3});
		rd(3'h6, {e, e}, 1'b0);
		rd(3'h6, {e, 4'h0}, 1'b0);
		wr(3'h4, 8'h10, 1'b0);
		pause(4);
		rd(3'h6, {4'h0, e[3], 1'b0, e[1:0]}, 1'b0);
		wr(3'h4, 8'h00, 1'b0);
		e = r[7:4] | 4'h4;
		@(posedge ref_clk_in);
		line_on <= e;
		pause(8);
		rd(3'h6, {e, e[3], 1'b0, e[1:0]}, 1'b0);
		@(posedge ref_clk_in);
		line_on <= 4'h0;
		pause(8);
		rd(3'h6, {4'h0, e[3], 1'b1, e[1:0]}, 1'b0);
		$display("test modem done");
		@(posedge ref_clk_in);
		{rx_line_err_in, rx_timeout_in, rx_data_ready_in} <= 3'h7;
		pause(2);
		rd(3'h2, 8'h01, 1'b0);
		wr(3'h1, 8'h0F, 1'b0);
		wr(3'h4, 8'h08, 1'b0);
		thr_empty_in <= 1'b1;
		pause(3);
		check({7'h0, irq_out}, 8'h01);
		for (i = 0; i < 4; i = i + 1)
		begin
			exp8 = 32'h060C_0402 >> (24 - 8 * i);
			rd(3'h2, exp8, 1'b0);
			@(posedge ref_clk_in);
			{rx_line_err_in, rx_timeout_in, rx_data_ready_in} <= 3'h7 >> (i + 1);
			pause(2);
		end
		rd(3'h2, 8'h01, 1'b0);
		line_on <= 4'h1;
		pause(8);
		rd(3'h2, 8'h00, 1'b0);
		rd(3'h6, 8'h11, 1'b0);
		rd(3'h2, 8'h01, 1'b0);
		$display("test priority done");
		wr(3'h2, 8'h10, 1'b1);
		wr(3'h1, 8'hE0, 1'b0);
		wr(3'h4, 8'h4A, 1'b0);
		wr(3'h6, 8'h24, 1'b0);
		rd(3'h6, 8'h24, 1'b0);
		wr(3'h2, 8'hF0, 1'b1);
		rx_char_in <= r;
		xoff2_char_in <= r;
		slow <= r[3:0];
		follow <= 1'b1;
		for (i = 0; i < 2; i = i + 1)
		begin
			@(posedge ref_clk_in);
			rx_char_valid_in <= (i == 0);
			xoff_rcvd_in <= (i == 1);
			@(posedge ref_clk_in);
			{rx_char_valid_in, xoff_rcvd_in} <= 2'h0;
			pause(2);
			rd(3'h2, 8'h10, 1'b0);
			rd(3'h2, 8'h01, 1'b0);
		end
		for (i = 0; i < 4; i = i + 1)
		begin
			exp8 = 32'h0F10_0908 >> (24 - 8 * i);
			@(posedge ref_clk_in);
			rx_level_in <= exp8[6:0];
			pause(24);
			check({rts_b_out, tx_halt_out}, {2{i == 1 || i == 2}});
		end
		rd(3'h2, 8'h20, 1'b0);
		$display("test flow done");
		summarize;
	end
endmodule
